// ==== grsa_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module grsa_host import grsa_pkg::*; (
  input  wire logic   mclk_in,
  output grsa_req_type req_out);
  initial req_out = '0;
  // No reserved bits exist in this map, so no masking or avoidance is due.
  task automatic put(input logic wr, rd, input logic [5:0] a,
                     input logic [7:0] d);
    @(negedge mclk_in) req_out = '{wr, rd, a, d};
    @(negedge mclk_in) req_out = '0;
  endtask : put
endmodule : grsa_host
`default_nettype wire

// ==== grsa_pkg.sv ====
`default_nettype none
package grsa_pkg;

  localparam int unsigned ADDR_W      = 6;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned NUM_ADDR    = 64;
  localparam logic [5:0]  ADDR_FIRST  = 6'h00;
  localparam logic [5:0]  ADDR_LAST   = 6'h3f;
  localparam logic [5:0]  RO_LAST     = 6'h0e;
  localparam logic [5:0]  RW_FIRST    = 6'h0f;
  localparam int unsigned NUM_RO      = 15;
  localparam int unsigned NUM_RW      = 49;
  localparam logic [5:0]  RESTART_ADR = 6'h14;
  localparam logic [5:0]  INTCLR_ADR  = 6'h21;
  localparam int unsigned INTCLR_BIT  = 7;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [7:0]  BYTE_ALL    = 8'hff;
  localparam logic [7:0]  INTCLR_MASK = 8'h80;
  localparam logic [7:0]  CFG_RESET   = 8'h00;

  typedef logic [DATA_W-1:0]              grsa_byte_type;
  typedef grsa_byte_type [NUM_RO-1:0]     grsa_status_type;
  typedef grsa_byte_type [NUM_RW-1:0]     grsa_cfg_type;

  typedef struct packed {
    logic                wr;
    logic                rd;
    logic [ADDR_W-1:0]   addr;
    grsa_byte_type       wdata;
  } grsa_req_type;

  typedef struct packed {
    logic                valid;
    grsa_byte_type       data;
  } grsa_rsp_type;

endpackage : grsa_pkg
`default_nettype wire

// ==== grsa_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Every register is one byte; each access moves exactly one byte.
// - Addresses 0x00 to 0x3F form one flat decoded space.
// - Writes to reserved bit positions are dropped and change nothing.
// - Addresses 0x00 to 0x0E are read-only; writes there are ignored.
// - Trigger bits are write-only and read back as zero, e.g. at 0x21.
// - Register 0x14 is write-only, reads zero, and a write starts restart.
module grsa_regs
#(
  parameter logic [grsa_pkg::NUM_ADDR*8-1:0] RSVD_MASK = '0
)
(
  input  wire logic                    mclk_in,
  input  wire logic                    rst_n_in,
  input  wire grsa_pkg::grsa_req_type  req_in,
  input  wire grsa_pkg::grsa_status_type status_in,
  output logic                         rd_valid_out,
  output logic [7:0]                   rd_data_out,
  output grsa_pkg::grsa_cfg_type       cfg_out,
  output logic                         restart_out,
  output logic                         int_clear_out
);
  import grsa_pkg::*;

  grsa_cfg_type  cfg_q;
  grsa_cfg_type  cfg_d;
  grsa_rsp_type  rsp_q;
  grsa_rsp_type  rsp_d;
  logic          restart_q;
  logic          int_clear_q;

  // Address decode over the whole 64-entry space.
  wire logic         is_ro      = (req_in.addr <= RO_LAST);
  wire logic         is_restart = (req_in.addr == RESTART_ADR);
  wire logic         is_intclr  = (req_in.addr == INTCLR_ADR);
  wire logic [5:0]   rw_index   = req_in.addr - RW_FIRST;
  wire logic [3:0]   ro_index   = req_in.addr[3:0];

  // Storable bits: reserved and trigger positions are never kept.
  wire logic [7:0]   rsvd_bits  = RSVD_MASK[req_in.addr*8 +: 8];
  wire logic [7:0]   trig_bits  = is_restart ? BYTE_ALL :
                                  is_intclr  ? INTCLR_MASK : BYTE_ZERO;
  wire logic [7:0]   keep_bits  = ~(rsvd_bits | trig_bits);

  // A write to the read-only range never reaches storage.
  wire logic         wr_store   = req_in.wr && !is_ro && !is_restart;
  wire logic         wr_restart = req_in.wr && is_restart;
  wire logic         wr_intclr  = req_in.wr && is_intclr &&
                                  req_in.wdata[INTCLR_BIT];

  wire grsa_byte_type rw_value  = is_ro ? status_in[ro_index] :
                                  (cfg_q[rw_index] & keep_bits);
  wire grsa_byte_type rd_value  = is_restart ? BYTE_ZERO : rw_value;

  // Restart wins over an ordinary write in the same cycle, since it returns
  // the whole configuration to its reset state anyway.
  always_comb
  begin
    cfg_d = cfg_q;
    if (restart_q)
    begin
      for (int i = 0; i < NUM_RW; i++)
      begin
        cfg_d[i] = CFG_RESET;
      end
    end
    else if (wr_store)
    begin
      cfg_d[rw_index] = (cfg_q[rw_index] & ~keep_bits)
                      | (req_in.wdata & keep_bits);
    end
  end

  // Reads answer one cycle later with exactly one byte.
  always_comb
  begin
    rsp_d.valid = req_in.rd;
    rsp_d.data  = req_in.rd ? rd_value : BYTE_ZERO;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cfg_q       <= '0;
      rsp_q       <= '0;
      restart_q   <= 1'b0;
      int_clear_q <= 1'b0;
    end
    else
    begin
      cfg_q       <= cfg_d;
      rsp_q       <= rsp_d;
      restart_q   <= wr_restart;
      int_clear_q <= wr_intclr;
    end
  end

  assign cfg_out       = cfg_q;
  assign rd_valid_out  = rsp_q.valid;
  assign rd_data_out   = rsp_q.data;
  assign restart_out   = restart_q;
  assign int_clear_out = int_clear_q;

endmodule : grsa_regs
`default_nettype wire

// ==== grsa_regs_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module grsa_regs_properties import grsa_pkg::*; (
  input wire logic mclk_in, rst_n_in, rd_valid_out, restart_out,
  input wire logic int_clear_out,
  input wire grsa_req_type req_in,
  input wire grsa_status_type status_in,
  input wire logic [7:0] rd_data_out,
  input wire grsa_cfg_type cfg_out);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic w = req_in.wr;
  wire logic [5:0] a = req_in.addr;
  rd_answer_a: assert property (req_in.rd |=> rd_valid_out)
    else $error("read not answered");
  rd_idle_a: assert property (!req_in.rd |=> rd_data_out == 8'h00)
    else $error("idle read data");
  ro_keep_a: assert property (w && a <= RO_LAST && !restart_out
    |=> $stable(cfg_out)) else $error("read-only write stored");
  rs_seq_a: assert property (w && a == RESTART_ADR
    |=> restart_out ##1 cfg_out == '0) else $error("restart missing");
  rs_read_a: assert property (req_in.rd && a == RESTART_ADR
    |=> rd_data_out == 8'h00) else $error("restart reg read");
  rs_only_a: assert property (w && a != RESTART_ADR |=> !restart_out)
    else $error("stray restart");
  clr_pulse_a: assert property (w && a == INTCLR_ADR && req_in.wdata[7]
    |=> int_clear_out && !cfg_out[18][7]) else $error("clear bit");
  rw_store_a: assert property (w && a >= RW_FIRST && a != RESTART_ADR
    && a != INTCLR_ADR && !restart_out |=> cfg_out[$past(a) - RW_FIRST]
    == $past(req_in.wdata)) else $error("byte not stored");
  cover property (w && a == RESTART_ADR);
  cover property (req_in.rd && a <= RO_LAST);
  cover property (w && a == INTCLR_ADR);
endmodule : grsa_regs_properties
bind grsa_regs grsa_regs_properties chk_u (.mclk_in, .rst_n_in,
  .rd_valid_out, .restart_out, .int_clear_out, .req_in, .status_in,
  .rd_data_out, .cfg_out);
`default_nettype wire

// ==== grsa_regs_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module grsa_regs_tb import grsa_pkg::*;;
  logic mclk_in = 0, rst_n_in = 0, v, rs, ic;
  logic [7:0] q;
  grsa_req_type req;
  grsa_status_type st;
  grsa_cfg_type cfg;
  int fail_count = 0, checks_done = 0, cyc = 0;
  always #4 mclk_in = ~mclk_in;
  grsa_host host_u (.mclk_in, .req_out(req));
  grsa_regs dut_u (.mclk_in, .rst_n_in, .req_in(req), .status_in(st),
    .rd_valid_out(v), .rd_data_out(q), .cfg_out(cfg), .restart_out(rs),
    .int_clear_out(ic));
  task automatic chk(input logic [7:0] s, e);
    checks_done++;
    if (s !== e) fail_count++;
    if (s !== e) $display("wrong value t=%0t %h %h", $time, s, e);
  endtask : chk
  task automatic rd(input logic [5:0] a, output logic [7:0] r);
    host_u.put(0, 1, a, 0);
    r = q;
    chk(8'(v), 8'h01);
  endtask : rd
  task automatic t_all;
    logic [7:0] r;
    host_u.put(1, 0, 6'h05, 8'hff);
    rd(6'h05, r); chk(r, 8'h26);
    host_u.put(1, 0, 6'h0f, 8'h5a);
    host_u.put(1, 0, 6'h3f, 8'ha5);
    rd(6'h0f, r); chk(r, 8'h5a);
    rd(6'h3f, r); chk(r, 8'ha5);
    host_u.put(1, 0, INTCLR_ADR, 8'hff);
    chk(8'(ic), 8'h01);
    rd(INTCLR_ADR, r); chk(r, 8'h7f);
    host_u.put(1, 0, RESTART_ADR, 8'h01);
    chk(8'(rs), 8'h01);
    rd(RESTART_ADR, r); chk(r, 8'h00);
    rd(6'h3f, r); chk(r, 8'h00);
    $display("access test done");
  endtask : t_all
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  always @(posedge mclk_in) if (++cyc == 2000) fail_count++;
  always @(negedge mclk_in) if (cyc >= 2000) close_out();
  initial
  begin
    foreach (st[i]) st[i] = 8'(i * 7 + 3);
    repeat (20) @(negedge mclk_in);
    rst_n_in = 1;
    t_all();
    close_out();
  end
endmodule : grsa_regs_tb
`default_nettype wire
